// >>> rtl/adc_seq_pkg.sv
package adc_seq_pkg;
  // Register indices
  localparam logic [1:0] OFS_RESULT_LO = 2'h0;
  localparam logic [1:0] OFS_RESULT_HI = 2'h1;
  localparam logic [1:0] OFS_CTRL      = 2'h2;
  localparam logic [1:0] OFS_CHANNEL   = 2'h3;
  // Control register bit positions
  localparam int BIT_ON    = 7;
  localparam int BIT_GO    = 6;
  localparam int BIT_CONT  = 5;
  localparam int BIT_DONE  = 4;
  localparam int BIT_IE    = 3;
  localparam int BIT_DIV_H = 2;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] CHAN_RST = 3'h0;
  // Conversion lengths in converter clocks
  localparam int NORMAL_CYCLES   = 13;
  localparam int EXTENDED_CYCLES = 25;
  // Sample point in half converter clocks
  localparam int NORMAL_SAMPLE_HALF   = 3;
  localparam int EXTENDED_SAMPLE_HALF = 27;
  localparam int CLK_PERIOD_NS = 40;

  typedef struct packed {
    logic       on;
    logic       cont;
    logic       ie;
    logic [2:0] div;
  } ctrl_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} conv_state_t;
endpackage : adc_seq_pkg

// >>> rtl/sar_adc_sequencer.sv
`timescale 1ns/100ps
// Overview of operation
// RL1 - Result is 10-bit unsigned code
// RL2 - Three-bit select picks one of eight
// RL3 - Channel register upper five bits read zero
// RL4 - Channel applies only while converter on
// RL5 - Channel change waits for conversion end
// RL6 - Mode bit picks single or continuous
// RL7 - Go bit starts, reads busy, self-clears
// RL8 - Start waits for converter clock edge
// RL9 - Prescaler held reset while converter off
// RL10 - Software keeps converter clock 50-200 kHz
// RL11 - Normal conversion lasts 13 clocks
// RL12 - First conversion extended, 25 clocks
// RL13 - Sample at 1.5 or 13.5 clocks
// RL14 - Completion writes result, sets flag
// RL15 - Continuous mode restarts immediately, go stays
// RL16 - Low read locks result until high read
// RL17 - Software reads low byte before high
// RL18 - Discarded result still sets flag, interrupt
// RL19 - Idle halt starts noise-canceling conversion
// RL20 - Idle conversion completion raises interrupt
// RL21 - Divide code 0,1 by 2, up to 128
// RL22 - Turning off aborts running conversion
// RL23 - Writing zero to go does nothing
// RL24 - Flag clears on vector or written one
// RL25 - Channel latched at each conversion start
module sar_adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int DATA_W = 10
)(
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic              CE,
  // Register port
  input  wire logic [1:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [7:0]        RDATA,
  // System
  input  wire logic              CPU_IDLE,
  input  wire logic              IRQ_ACK,
  output logic                   IRQ,
  // Analog core
  output logic      [2:0]        CHAN_SEL,
  output logic                   SAMPLE,
  output logic                   CORE_ON,
  input  wire logic [DATA_W-1:0] CORE_CODE
);
  import adc_seq_pkg::*;

  if (DATA_W != 10)
  begin : g_bad_width
    $error("DATA_W must be 10");
  end

  ctrl_t             ctrl_r;
  logic              go_r;
  logic              done_r;
  logic              ext_r;
  logic [2:0]        chan_r;
  logic [2:0]        chan_act_r;
  logic [DATA_W-1:0] result_r;
  logic              lock_r;
  logic [6:0]        pre_r;
  logic              tick;
  logic              mid;
  logic [4:0]        conv_ticks_r;
  logic [5:0]        half_r;
  logic              idle_d_r;
  logic              sample_r;
  logic [7:0]        rdata_r;
  conv_state_t       st_r;
  logic              complete;
  logic              wr_ctrl;
  logic              start_req;
  logic              idle_start;
  logic [5:0]        len_half;

  assign wr_ctrl = WR && (ADDR == OFS_CTRL);
  // RL19 idle auto start
  assign idle_start = CPU_IDLE && !idle_d_r && ctrl_r.on && !go_r && !ctrl_r.cont && ctrl_r.ie;
  // RL23 zero write ignored
  assign start_req = (wr_ctrl && WDATA[BIT_GO] && WDATA[BIT_ON]) || idle_start;
  assign len_half = ext_r ? 6'(2 * EXTENDED_CYCLES) : 6'(2 * NORMAL_CYCLES);
  assign complete = (st_r == ST_CONV) && tick && (half_r == len_half - 6'h2) && ctrl_r.on;

  // RL21 divide select
  always_comb
  begin
    case (ctrl_r.div)
      3'h0, 3'h1: tick = (pre_r[0] == 1'b1);
      3'h2: tick = (pre_r[1:0] == 2'h3);
      3'h3: tick = (pre_r[2:0] == 3'h7);
      3'h4: tick = (pre_r[3:0] == 4'hf);
      3'h5: tick = (pre_r[4:0] == 5'h1f);
      3'h6: tick = (pre_r[5:0] == 6'h3f);
      default: tick = (pre_r == 7'h7f);
    endcase
  end

  // Midpoint of each converter clock, for the half-cycle hold instant
  always_comb
  begin
    case (ctrl_r.div)
      3'h0, 3'h1: mid = (pre_r[0] == 1'b0);
      3'h2: mid = (pre_r[1:0] == 2'h1);
      3'h3: mid = (pre_r[2:0] == 3'h3);
      3'h4: mid = (pre_r[3:0] == 4'h7);
      3'h5: mid = (pre_r[4:0] == 5'h0f);
      3'h6: mid = (pre_r[5:0] == 6'h1f);
      default: mid = (pre_r == 7'h3f);
    endcase
  end

  // RL9 prescaler gated
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      pre_r <= 7'h00;
    else if (CE)
      pre_r <= ctrl_r.on ? pre_r + 7'h01 : 7'h00;
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_r <= ctrl_t'(6'h00);
      chan_r <= CHAN_RST;
    end
    else if (CE)
    begin
      if (wr_ctrl)
        ctrl_r <= '{WDATA[BIT_ON], WDATA[BIT_CONT], WDATA[BIT_IE], WDATA[BIT_DIV_H:0]};
      // RL2 channel field
      if (WR && ADDR == OFS_CHANNEL)
        chan_r <= WDATA[2:0];
    end
  end

  // Sequencer: half counter counts converter half periods, stepping by two on each converter clock tick in ST_CONV, cleared at completion
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      st_r   <= ST_IDLE;
      go_r   <= 1'b0;
      ext_r  <= 1'b1;
      half_r <= 6'h00;
      chan_act_r <= CHAN_RST;
    end
    else if (CE)
    begin
      // RL22 abort on off; a write turning on with go set goes to ST_WAIT for a tick
      if (wr_ctrl ? !WDATA[BIT_ON] : !ctrl_r.on)
      begin
        st_r <= ST_IDLE;
        go_r <= 1'b0;
        ext_r <= 1'b1;
        chan_act_r <= chan_r;
      end
      else
      begin
        case (st_r)
          ST_IDLE:
          begin
            // RL4 idle converter follows selection
            chan_act_r <= chan_r;
            // RL7 go starts
            if (start_req)
            begin
              go_r <= 1'b1;
              st_r <= ST_WAIT;
            end
          end
          ST_WAIT:
            // RL8 wait clock edge
            if (tick)
            begin
              st_r <= ST_CONV;
              half_r <= 6'h00;
              // RL25 latch channel
              chan_act_r <= chan_r;
            end
          ST_CONV:
            if (tick)
            begin
              half_r <= half_r + 6'h2;
              if (complete)
              begin
                ext_r <= 1'b0;
                half_r <= 6'h00;
                // RL5 switch at completion
                chan_act_r <= chan_r;
                // RL15 continuous keeps running
                // RL14 single clears go
                if (!ctrl_r.cont)
                begin
                  go_r <= 1'b0;
                  st_r <= ST_IDLE;
                end
              end
            end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // RL13 sample point
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      sample_r <= 1'b0;
    else if (CE)
      sample_r <= (st_r == ST_CONV) && ctrl_r.on && mid &&
                  (half_r == (ext_r ? 6'(EXTENDED_SAMPLE_HALF - 1) : 6'(NORMAL_SAMPLE_HALF - 1)));
  end

  // RL16 read lock
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      lock_r <= 1'b0;
      result_r <= '0;
    end
    else if (CE)
    begin
      if (RD && ADDR == OFS_RESULT_LO)
        lock_r <= 1'b1;
      else if (RD && ADDR == OFS_RESULT_HI)
        lock_r <= 1'b0;
      // RL1 result store
      if (complete && !lock_r)
        result_r <= CORE_CODE;
    end
  end

  // RL24 flag clear
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      done_r <= 1'b0;
    else if (CE)
    begin
      // RL18 set despite lock
      if (complete)
        done_r <= 1'b1;
      else if (IRQ_ACK || (wr_ctrl && WDATA[BIT_DONE]))
        done_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      idle_d_r <= 1'b0;
    else if (CE)
      idle_d_r <= CPU_IDLE;
  end

  // RL3 reserved zero
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      rdata_r <= 8'h00;
    else if (CE)
    begin
      rdata_r <= 8'h00;
      if (RD)
        case (ADDR)
          OFS_RESULT_LO: rdata_r <= result_r[7:0];
          OFS_RESULT_HI: rdata_r <= {6'h00, result_r[9:8]};
          OFS_CTRL: rdata_r <= {ctrl_r.on, go_r, ctrl_r.cont, done_r, ctrl_r.ie, ctrl_r.div};
          default: rdata_r <= {5'h00, chan_r};
        endcase
    end
  end

  assign RDATA = rdata_r;
  // RL20 interrupt out
  assign IRQ = done_r && ctrl_r.ie;
  // RL4 channel only when on
  // RL5 switch at completion
  assign CHAN_SEL = ctrl_r.on ? chan_act_r : CHAN_RST;
  assign SAMPLE = sample_r;
  assign CORE_ON = ctrl_r.on;

  // RL11 RL12 independent clock count
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      conv_ticks_r <= 5'h00;
    else if (CE)
    begin
      if (st_r != ST_CONV || complete)
        conv_ticks_r <= 5'h00;
      else if (tick)
        conv_ticks_r <= conv_ticks_r + 5'h01;
    end
  end

  // RL11 normal length
  property p_normal_len;
    @(posedge MCLK) disable iff (RST)
    (complete && CE && !ext_r) |-> conv_ticks_r == 5'(NORMAL_CYCLES - 1);
  endproperty
  a_normal_len: assert property (p_normal_len) else $error("normal length wrong"); // RL11

  property p_ext_len;
    @(posedge MCLK) disable iff (RST)
    (complete && CE && ext_r) |-> conv_ticks_r == 5'(EXTENDED_CYCLES - 1);
  endproperty
  a_ext_len: assert property (p_ext_len) else $error("extended length wrong"); // RL12

  property p_single_clear;
    @(posedge MCLK) disable iff (RST)
    (complete && CE && !ctrl_r.cont) |=> !go_r && done_r;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("go not cleared"); // RL14

  property p_cont_go;
    @(posedge MCLK) disable iff (RST)
    (complete && CE && ctrl_r.cont && !wr_ctrl) |=> go_r;
  endproperty
  a_cont_go: assert property (p_cont_go) else $error("go dropped"); // RL15

  property p_lock;
    @(posedge MCLK) disable iff (RST)
    (lock_r && CE) |=> $stable(result_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked result changed"); // RL16

  property p_off;
    @(posedge MCLK) disable iff (RST)
    (!ctrl_r.on && CE && !(wr_ctrl && WDATA[BIT_ON])) |=> (pre_r == 7'h00) && (st_r == ST_IDLE);
  endproperty
  a_off: assert property (p_off) else $error("off not reset"); // RL9

  property p_rsv;
    @(posedge MCLK) disable iff (RST)
    (RD && CE && ADDR == OFS_CHANNEL) |=> RDATA[7:3] == 5'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set"); // RL3

  property p_irq;
    @(posedge MCLK) disable iff (RST)
    (complete && CE && ctrl_r.ie && !wr_ctrl) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt"); // RL18

  property p_wait;
    @(posedge MCLK) disable iff (RST)
    (st_r == ST_WAIT && !tick && CE && ctrl_r.on && !wr_ctrl) |=> st_r == ST_WAIT;
  endproperty
  a_wait: assert property (p_wait) else $error("start without tick"); // RL8
endmodule : sar_adc_sequencer

// >>> tb/sar_adc_sequencer_test.sv
`timescale 1ns/100ps
module sar_adc_sequencer_test;
  import adc_seq_pkg::*;
  logic       MCLK      = 1'b0;
  logic       RST       = 1'b1;
  logic       CE        = 1'b1;
  logic       WR        = 1'b0;
  logic       RD        = 1'b0;
  logic       CPU_IDLE  = 1'b0;
  logic       IRQ_ACK   = 1'b0;
  logic [1:0] ADDR      = 2'h0;
  logic [7:0] WDATA     = 8'h00;
  logic [9:0] CORE_CODE = 10'h2a5;
  logic [7:0] RDATA;
  logic [7:0] rd;
  logic [2:0] CHAN_SEL;
  logic       IRQ;
  logic       SAMPLE;
  logic       CORE_ON;
  int         mismatches = 0;
  int         n_compared = 0;
  int         cycles     = 0;
  int         len;
  int         smp;

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end

  always #20 MCLK = ~MCLK;

  sar_adc_sequencer u_dut (
    .MCLK(MCLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CPU_IDLE(CPU_IDLE), .IRQ_ACK(IRQ_ACK), .IRQ(IRQ),
    .CHAN_SEL(CHAN_SEL), .SAMPLE(SAMPLE), .CORE_ON(CORE_ON), .CORE_CODE(CORE_CODE)
  );

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [1:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    rd = RDATA;
  endtask : rdr

  // Bounded wait for completion, noting the hold instant
  task automatic wirq();
    len = 0;
    smp = -1000;
    while (IRQ !== 1'b1 && len < 4000)
    begin
      @(negedge MCLK);
      len++;
      if (SAMPLE === 1'b1)
        smp = len;
    end
    `CHK("irq", 1'b1, IRQ)
  endtask : wirq

  task automatic ack();
    @(posedge MCLK);
    IRQ_ACK <= 1'b1;
    @(posedge MCLK);
    IRQ_ACK <= 1'b0;
    @(negedge MCLK);
    `CHK("irq_ack", 1'b0, IRQ)
  endtask : ack

  task automatic t_first();
    rdr(OFS_CTRL);
    `CHK("ctrl_rst", CTRL_RST, rd)
    wr(OFS_CHANNEL, 8'hfa);
    rdr(OFS_CHANNEL);
    `CHK("chan_rd", 8'h02, rd)
    `CHK("chan_off", 3'h0, CHAN_SEL)
    wr(OFS_CTRL, 8'hc8);
    @(negedge MCLK);
    `CHK("chan_on", 3'h2, CHAN_SEL)
    rdr(OFS_CTRL);
    `CHK("go_busy", 1'b1, rd[BIT_GO])
    wirq();
    `CHK("ext_gap", 1'b1, (len - smp) inside {[22:25]})
    rdr(OFS_CTRL);
    `CHK("ctrl_done", 8'h98, rd)
    rdr(OFS_RESULT_LO);
    `CHK("res_lo", 8'ha5, rd)
    rdr(OFS_RESULT_HI);
    `CHK("res_hi", 8'h02, rd)
    wr(OFS_CTRL, 8'h98);
    @(negedge MCLK);
    `CHK("flag_w1c", 1'b0, IRQ)
    $display("test first done");
  endtask : t_first

  task automatic t_norm();
    wr(OFS_CTRL, 8'hcb);
    // Let the conversion start so the new channel must wait
    repeat (8) @(posedge MCLK);
    wr(OFS_CHANNEL, 8'h05);
    @(negedge MCLK);
    `CHK("chan_hold", 3'h2, CHAN_SEL)
    wirq();
    `CHK("norm_gap", 1'b1, (len - smp) inside {[91:94]})
    `CHK("chan_new", 3'h5, CHAN_SEL)
    ack();
    $display("test normal done");
  endtask : t_norm

  task automatic t_lock();
    rdr(OFS_RESULT_LO);
    CORE_CODE <= 10'h15a;
    wr(OFS_CTRL, 8'hc9);
    wirq();
    rdr(OFS_RESULT_HI);
    `CHK("lock_hi", 8'h02, rd)
    rdr(OFS_RESULT_LO);
    `CHK("lock_lo", 8'ha5, rd)
    rdr(OFS_RESULT_HI);
    `CHK("unlock_hi", 8'h02, rd)
    ack();
    wr(OFS_CTRL, 8'hca);
    wirq();
    rdr(OFS_RESULT_LO);
    `CHK("new_lo", 8'h5a, rd)
    rdr(OFS_RESULT_HI);
    `CHK("new_hi", 8'h01, rd)
    ack();
    wr(OFS_CTRL, 8'h88);
    repeat (60) @(negedge MCLK);
    `CHK("go0_irq", 1'b0, IRQ)
    rdr(OFS_CTRL);
    `CHK("go0_ctrl", 8'h88, rd)
    $display("test lock done");
  endtask : t_lock

  task automatic t_cont();
    wr(OFS_CTRL, 8'he8);
    wirq();
    ack();
    wirq();
    rdr(OFS_CTRL);
    `CHK("cont_go", 1'b1, rd[BIT_GO])
    // Frozen block must ignore the off write
    @(posedge MCLK);
    CE <= 1'b0;
    wr(OFS_CTRL, 8'h10);
    @(negedge MCLK);
    `CHK("ce_hold", 1'b1, CORE_ON)
    `CHK("ce_irq", 1'b1, IRQ)
    @(posedge MCLK);
    CE <= 1'b1;
    wr(OFS_CTRL, 8'h10);
    @(negedge MCLK);
    `CHK("core_off", 1'b0, CORE_ON)
    repeat (60) @(negedge MCLK);
    rdr(OFS_CTRL);
    `CHK("abort", 8'h00, rd)
    $display("test continuous done");
  endtask : t_cont

  task automatic t_idle();
    wr(OFS_CTRL, 8'h8f);
    @(posedge MCLK);
    CPU_IDLE <= 1'b1;
    wirq();
    `CHK("idle_gap", 1'b1, (len - smp) inside {[1471:1473]})
    @(posedge MCLK);
    CPU_IDLE <= 1'b0;
    ack();
    $display("test idle done");
  endtask : t_idle

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Whole run needs well under this
  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    t_first();
    t_norm();
    t_lock();
    t_cont();
    t_idle();
    conclude();
  end
endmodule : sar_adc_sequencer_test
